// File: rtl/icc_pkg.sv
// constants, modes and register map of the input capture channel
package icc_pkg;
   localparam logic [31:0] ICC_CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] ICC_BUF_OFS = 32'h0000_0004;
   localparam int ICC_ADDR_LSB = 2;
   localparam int ICC_ADDR_BITS = 4;
   localparam int ICC_ON_BIT = 15;
   localparam int ICC_STOP_IDLE_BIT = 13;
   localparam int ICC_FIRST_EDGE_BIT = 9;
   localparam int ICC_WIDE_BIT = 8;
   localparam int ICC_TMR_BIT = 7;
   localparam int ICC_ICNT_LSB = 5;
   localparam int ICC_OV_BIT = 4;
   localparam int ICC_BNE_BIT = 3;
   localparam int ICC_MODE_LSB = 0;
   localparam logic [31:0] ICC_CTRL_WMASK = 32'h0000_A3E7;
   localparam logic [31:0] ICC_CTRL_RESET = 32'h0000_0000;
   localparam int ICC_DEPTH = 4;
   localparam logic [3:0] ICC_PSC4_LAST = 4'h3;
   localparam logic [3:0] ICC_PSC16_LAST = 4'hF;
   localparam logic [1:0] ICC_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] ICC_HRESP_OKAY = 2'h0;

   typedef enum logic [2:0] {
      ICC_MODE_OFF = 3'b000,
      ICC_MODE_EDGE = 3'b001,
      ICC_MODE_FALL = 3'b010,
      ICC_MODE_RISE = 3'b011,
      ICC_MODE_PSC4 = 3'b100,
      ICC_MODE_PSC16 = 3'b101,
      ICC_MODE_FIRST = 3'b110,
      ICC_MODE_IRQ = 3'b111
   } icc_mode_t;
endpackage

// File: rtl/icc_input_capture.sv
// input capture channel with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
module icc_input_capture
   import icc_pkg::*;
#(
   parameter int DEPTH = ICC_DEPTH
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic [1:0] hresp,
   input wire logic capture_input_pin,
   input wire logic [15:0] time_base_two,
   input wire logic [15:0] time_base_three,
   input wire logic cpu_idle,
   input wire logic cpu_sleep,
   output logic capture_irq,
   output logic wake_request
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [31:0] ctrl_r;
   logic [31:0] mem_r [DEPTH];
   logic [PW-1:0] wptr_r;
   logic [PW-1:0] rptr_r;
   logic [CW-1:0] cnt_r;
   logic ovf_r;
   logic [3:0] psc_r;
   logic [1:0] icnt_r;
   logic first_done_r;
   logic sync1_r;
   logic sync2_r;
   logic prev_r;
   logic wr_pend_r;
   logic [ICC_ADDR_BITS-1:0] wr_idx_r;
   logic [31:0] hrdata_r;
   logic irq_r;
   logic wake_r;

   // upper address bits are not decoded, so the two registers repeat every 64 bytes
   function automatic logic [ICC_ADDR_BITS-1:0] reg_index(
      input logic [31:0] a
   );
      return a[ICC_ADDR_LSB +: ICC_ADDR_BITS];
   endfunction

   // bus decode
   wire logic acc = hsel && hready && htrans == ICC_HTRANS_NONSEQ;
   wire logic [ICC_ADDR_BITS-1:0] idx = reg_index(haddr);
   wire logic hit_ctrl = idx == reg_index(ICC_CTRL_OFS);
   wire logic hit_buf = idx == reg_index(ICC_BUF_OFS);
   wire logic rd_ctrl = acc && !hwrite && hit_ctrl;
   wire logic rd_buf = acc && !hwrite && hit_buf;
   wire logic wr_ctrl =
      wr_pend_r && wr_idx_r == reg_index(ICC_CTRL_OFS);

   // control fields
   wire logic on = ctrl_r[ICC_ON_BIT];
   wire logic stop_in_idle = ctrl_r[ICC_STOP_IDLE_BIT];
   wire logic first_edge_select = ctrl_r[ICC_FIRST_EDGE_BIT];
   wire logic wide_capture_select = ctrl_r[ICC_WIDE_BIT];
   wire logic time_base_select = ctrl_r[ICC_TMR_BIT];
   wire logic [1:0] interrupt_count_field = ctrl_r[ICC_ICNT_LSB +: 2];
   wire icc_mode_t mode = icc_mode_t'(ctrl_r[ICC_MODE_LSB +: 3]);

   wire logic empty = cnt_r == CW'(0);
   wire logic full = cnt_r == CW'(DEPTH);
   wire logic low_power = cpu_idle || cpu_sleep;
   // stop-in-idle freezes the capture logic but not the synchroniser
   wire logic halt = stop_in_idle && cpu_idle;
   wire logic run = on && !halt;

   // edge detect on the synchronised pin
   wire logic rise = sync2_r && !prev_r;
   wire logic fall = !sync2_r && prev_r;
   wire logic any_edge = rise || fall;
   wire logic first_edge = first_edge_select ? rise : fall;
   wire logic psc_last = (mode == ICC_MODE_PSC4) ?
      psc_r == ICC_PSC4_LAST : psc_r == ICC_PSC16_LAST;

   logic edge_ev;
   always_comb begin
      edge_ev = 1'b0;
      unique case (mode)
         ICC_MODE_OFF: edge_ev = 1'b0;
         ICC_MODE_EDGE: edge_ev = any_edge;
         ICC_MODE_FALL: edge_ev = fall;
         ICC_MODE_RISE: edge_ev = rise;
         ICC_MODE_PSC4: edge_ev = rise && psc_last;
         ICC_MODE_PSC16: edge_ev = rise && psc_last;
         ICC_MODE_FIRST:
            edge_ev = first_done_r ? any_edge : first_edge;
         ICC_MODE_IRQ: edge_ev = 1'b0;
      endcase
   end
   wire logic cap_ev = run && edge_ev;

   // time base choice; timer three forms the upper half of the chain
   wire logic [31:0] cap_val = wide_capture_select ?
      {time_base_three, time_base_two} :
      (time_base_select ? {16'h0000, time_base_two} :
      {16'h0000, time_base_three});

   wire logic pop = rd_buf && !empty;
   // a pop in the same cycle frees a slot, so a full buffer still accepts
   wire logic push = cap_ev && (!full || pop);
   wire logic ovf_set = cap_ev && full && !pop;
   wire logic irq_ev = (push && icnt_r == interrupt_count_field) ||
      (run && mode == ICC_MODE_IRQ && low_power && any_edge);

   wire logic [31:0] ctrl_rd = {16'h0000,
      ctrl_r[15:5], ovf_r, !empty, ctrl_r[2:0]};
   wire logic [31:0] rd_next = rd_ctrl ? ctrl_rd :
      (pop ? mem_r[rptr_r] : 32'h0000_0000);

   // pin synchroniser; the second stage and its delayed copy prev_r feed the edge detect
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         sync1_r <= capture_input_pin;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   // register writes land in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_idx_r <= '0;
         hrdata_r <= 32'h0000_0000;
      end else begin
         wr_pend_r <= acc && hwrite;
         wr_idx_r <= idx;
         hrdata_r <= rd_next;
      end
   end

   // config stays writable in every state; clearing enable resets the rest
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= ICC_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_r <= hwdata & ICC_CTRL_WMASK;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r <= '0;
         ovf_r <= 1'b0;
      end else if (!on) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r <= '0;
         ovf_r <= 1'b0;
      end else begin
         if (push) begin
            wptr_r <= wptr_r + PW'(1);
         end
         if (pop) begin
            rptr_r <= rptr_r + PW'(1);
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + CW'(1);
         end else if (pop && !push) begin
            cnt_r <= cnt_r - CW'(1);
         end
         if (ovf_set) begin
            ovf_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge hclk) begin
      if (push) begin
         mem_r[wptr_r] <= cap_val;
      end
   end

   // prescaler, first-edge tracker and interrupt counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         psc_r <= 4'h0;
         first_done_r <= 1'b0;
         icnt_r <= 2'h0;
      end else if (!on || wr_ctrl) begin
         // a mode change restarts prescaling and the first-edge wait
         psc_r <= 4'h0;
         first_done_r <= 1'b0;
         icnt_r <= 2'h0;
      end else if (run) begin
         if (rise && (mode == ICC_MODE_PSC4 || mode == ICC_MODE_PSC16)) begin
            psc_r <= psc_last ? 4'h0 : psc_r + 4'h1;
         end
         if (cap_ev && mode == ICC_MODE_FIRST) begin
            first_done_r <= 1'b1;
         end
         if (push) begin
            icnt_r <= (icnt_r == interrupt_count_field) ? 2'h0 :
               icnt_r + 2'h1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_r <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         irq_r <= irq_ev;
         wake_r <= run && mode != ICC_MODE_OFF &&
            low_power && any_edge;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = 1'b1;
   assign hresp = ICC_HRESP_OKAY;
   assign capture_irq = irq_r;
   assign wake_request = wake_r;

   property p_ovf_full;
      @(posedge hclk) disable iff (!hresetn)
      (cap_ev && full && !pop) |=> ovf_r && full;
   endproperty
   a_ovf_full: assert property (p_ovf_full)
      else $error("overflow not flagged on capture into full buffer");

   property p_bne_after_push;
      @(posedge hclk) disable iff (!hresetn)
      (on && push && empty) |=> !empty;
   endproperty
   a_bne_after_push: assert property (p_bne_after_push)
      else $error("buffer not empty flag missing after capture");

   property p_disable_clear;
      @(posedge hclk) disable iff (!hresetn)
      !on |=> empty && !ovf_r && !capture_irq;
   endproperty
   a_disable_clear: assert property (p_disable_clear)
      else $error("disabled channel kept state or interrupt");

   property p_mode_off;
      @(posedge hclk) disable iff (!hresetn)
      (mode == ICC_MODE_OFF || mode == ICC_MODE_IRQ) |-> !cap_ev;
   endproperty
   a_mode_off: assert property (p_mode_off)
      else $error("capture taken in a non-capturing mode");

   property p_rise_only;
      @(posedge hclk) disable iff (!hresetn)
      (run && mode == ICC_MODE_RISE) |-> cap_ev == rise;
   endproperty
   a_rise_only: assert property (p_rise_only)
      else $error("rising mode captured wrong edge");

   property p_psc4;
      @(posedge hclk) disable iff (!hresetn)
      (cap_ev && mode == ICC_MODE_PSC4) |-> psc_r == ICC_PSC4_LAST
         ##1 psc_r == 4'h0;
   endproperty
   a_psc4: assert property (p_psc4)
      else $error("fourth-edge capture at wrong count");

   property p_psc16;
      @(posedge hclk) disable iff (!hresetn)
      (cap_ev && mode == ICC_MODE_PSC16) |-> psc_r == ICC_PSC16_LAST;
   endproperty
   a_psc16: assert property (p_psc16)
      else $error("sixteenth-edge capture at wrong count");

   property p_halt;
      @(posedge hclk) disable iff (!hresetn)
      (stop_in_idle && cpu_idle) |-> !cap_ev && !push;
   endproperty
   a_halt: assert property (p_halt)
      else $error("capture while halted in idle");

   property p_wide;
      @(posedge hclk) disable iff (!hresetn)
      (push && wide_capture_select) |=> mem_r[$past(wptr_r)] ==
         {$past(time_base_three), $past(time_base_two)};
   endproperty
   a_wide: assert property (p_wide)
      else $error("wide capture stored wrong value");

   property p_narrow;
      @(posedge hclk) disable iff (!hresetn)
      (push && !wide_capture_select) |=> mem_r[$past(wptr_r)] ==
         ($past(time_base_select) ? {16'h0000, $past(time_base_two)} :
         {16'h0000, $past(time_base_three)});
   endproperty
   a_narrow: assert property (p_narrow)
      else $error("narrow capture used wrong timer");

   property p_cnt_bound;
      @(posedge hclk) disable iff (!hresetn)
      cnt_r <= CW'(DEPTH);
   endproperty
   a_cnt_bound: assert property (p_cnt_bound)
      else $error("buffer count beyond its depth");

   property p_irq_count;
      @(posedge hclk) disable iff (!hresetn)
      (push && icnt_r == interrupt_count_field) |=> capture_irq;
   endproperty
   a_irq_count: assert property (p_irq_count)
      else $error("interrupt missing after counted captures");

   property p_edge_mode;
      @(posedge hclk) disable iff (!hresetn)
      (run && mode == ICC_MODE_EDGE) |-> cap_ev == any_edge;
   endproperty
   a_edge_mode: assert property (p_edge_mode)
      else $error("edge mode missed an edge");

   property p_fall_only;
      @(posedge hclk) disable iff (!hresetn)
      (run && mode == ICC_MODE_FALL) |-> cap_ev == fall;
   endproperty
   a_fall_only: assert property (p_fall_only)
      else $error("falling mode captured wrong edge");

   property p_first_wrong;
      @(posedge hclk) disable iff (!hresetn)
      (run && mode == ICC_MODE_FIRST && !first_done_r &&
         (first_edge_select ? fall : rise)) |-> !cap_ev;
   endproperty
   a_first_wrong: assert property (p_first_wrong)
      else $error("first capture took the unselected edge");

   property p_first_after;
      @(posedge hclk) disable iff (!hresetn)
      (run && mode == ICC_MODE_FIRST && first_done_r) |-> cap_ev == any_edge;
   endproperty
   a_first_after: assert property (p_first_after)
      else $error("edge missed after the first capture");

   property p_irq_awake;
      @(posedge hclk) disable iff (!hresetn)
      (mode == ICC_MODE_IRQ && !low_power) |=> !capture_irq;
   endproperty
   a_irq_awake: assert property (p_irq_awake)
      else $error("pin interrupt raised while the cpu was awake");

   property p_no_wake;
      @(posedge hclk) disable iff (!hresetn)
      (!low_power || !on) |=> !wake_request;
   endproperty
   a_no_wake: assert property (p_no_wake)
      else $error("wake request while awake or disabled");

   property p_ctrl_flags;
      @(posedge hclk) disable iff (!hresetn)
      rd_ctrl |=> hrdata[ICC_BNE_BIT] == !$past(empty) &&
         hrdata[ICC_OV_BIT] == $past(ovf_r);
   endproperty
   a_ctrl_flags: assert property (p_ctrl_flags)
      else $error("status bits read back wrong");

   property p_empty_read;
      @(posedge hclk) disable iff (!hresetn)
      (rd_buf && empty) |=> hrdata == 32'h0000_0000;
   endproperty
   a_empty_read: assert property (p_empty_read)
      else $error("read of an empty buffer returned data");

   property p_ovf_hold;
      @(posedge hclk) disable iff (!hresetn)
      (ovf_r && on) |=> ovf_r;
   endproperty
   a_ovf_hold: assert property (p_ovf_hold)
      else $error("overflow flag dropped while enabled");
endmodule
`default_nettype wire

// File: tb/icc_far_model.sv
// far side model: capture pin driver and the two shared timers
`timescale 1ns/1ps
`default_nettype none
module icc_far_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hold,
   input wire logic pin_lvl,
   output logic capture_input_pin,
   output logic [15:0] time_base_two,
   output logic [15:0] time_base_three
);
   // timers freeze on hold so a capture value can be predicted
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         time_base_two <= 16'h1234;
         time_base_three <= 16'hA5C0;
      end else if (!hold) begin
         time_base_two <= time_base_two + 16'h0001;
         time_base_three <= time_base_three - 16'h0003;
      end
   end
   assign capture_input_pin = pin_lvl;
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the input capture channel
`timescale 1ns/1ps
`default_nettype none
module tb;
   import icc_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hold = 0, pin = 0;
   logic cpu_idle = 0, cpu_sleep = 0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
   wire logic [31:0] hrdata;
   wire logic hreadyout, capture_irq, wake_request, cpin;
   wire logic [1:0] hresp;
   wire logic [15:0] tb2, tb3;
   int err_total = 0, checks_done = 0, irq_n = 0, wake_n = 0;

   icc_input_capture #(.DEPTH(ICC_DEPTH)) dut_u (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .capture_input_pin(cpin), .time_base_two(tb2),
      .time_base_three(tb3), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
      .capture_irq(capture_irq), .wake_request(wake_request));
   icc_far_model far_u (.hclk(hclk), .hresetn(hresetn), .hold(hold),
      .pin_lvl(pin), .capture_input_pin(cpin), .time_base_two(tb2),
      .time_base_three(tb3));

   initial forever #2.5 hclk = ~hclk;
   always @(posedge hclk) begin
      if (capture_irq === 1'b1) irq_n++;
      if (wake_request === 1'b1) wake_n++;
   end

   task automatic chk(input logic [31:0] got, exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // single transfer; read data taken at the data-phase edge
   task automatic bus(input logic [31:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= ICC_HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] q);
      bus(a, 1'b0, 32'h0000_0000, q);
   endtask
   // one pin change, then pop what it stored; keeps edges well apart
   task automatic edge_drain(inout int caps);
      logic [31:0] q;
      @(posedge hclk);
      pin <= ~pin;
      repeat (4) @(posedge hclk);
      rd(ICC_CTRL_OFS, q);
      if (q[ICC_BNE_BIT] === 1'b1) begin
         rd(ICC_BUF_OFS, q);
         caps++;
      end
   endtask
   task automatic run(input logic [31:0] ctrl, input int n, output int caps);
      wr(ICC_CTRL_OFS, 32'h0000_0000);
      repeat (2) @(posedge hclk);
      wr(ICC_CTRL_OFS, ctrl);
      irq_n = 0;
      wake_n = 0;
      caps = 0;
      repeat (n) edge_drain(caps);
   endtask

   task automatic t_regs();
      logic [31:0] q;
      rd(ICC_CTRL_OFS, q);
      chk(q, 32'h0000_0000, "ctrl reset");
      chk({30'h0, hresp}, 32'h0000_0000, "okay");
      chk({31'h0, hreadyout}, 32'h0000_0001, "ready");
      wr(ICC_CTRL_OFS, 32'hFFFF_7FFF);
      rd(ICC_CTRL_OFS, q);
      chk(q, 32'h0000_23E7, "ctrl mask");
      wr(32'h0000_0008, 32'hFFFF_FFFF);
      rd(32'h0000_0008, q);
      chk(q, 32'h0000_0000, "unmapped");
      rd(ICC_BUF_OFS, q);
      chk(q, 32'h0000_0000, "empty buffer");
   endtask
   task automatic t_tbase();
      logic [31:0] ctl [4] = '{32'h0000_8083, 32'h0000_8003,
                                32'h0000_8103, 32'h0000_8183};
      logic [31:0] q, e;
      int c;
      for (int i = 0; i < 4; i++) begin
         run(ctl[i], 0, c);
         @(posedge hclk);
         pin <= 1'b1;
         repeat (4) @(posedge hclk);
         rd(ICC_BUF_OFS, q);
         e = ctl[i][8] ? {tb3, tb2} : {16'h0000, ctl[i][7] ? tb2 : tb3};
         chk(q, e, "time base");
         edge_drain(c);
      end
   endtask
   task automatic t_fifo();
      logic [31:0] q;
      logic [15:0] ex [5];
      int c;
      run(32'h0000_8083, 0, c);
      for (int i = 0; i < 5; i++) begin
         hold <= 1'b0;
         repeat (3) @(posedge hclk);
         hold <= 1'b1;
         pin <= 1'b1;
         repeat (4) @(posedge hclk);
         ex[i] = tb2;
         pin <= 1'b0;
         repeat (4) @(posedge hclk);
      end
      rd(ICC_CTRL_OFS, q);
      chk(q & 32'h0000_0018, 32'h0000_0018, "full");
      for (int i = 0; i < 4; i++) begin
         rd(ICC_BUF_OFS, q);
         chk(q, {16'h0000, ex[i]}, "order");
      end
      rd(ICC_CTRL_OFS, q);
      chk(q & 32'h0000_0018, 32'h0000_0010, "drained");
      run(32'h0000_8083, 0, c);
      rd(ICC_CTRL_OFS, q);
      chk(q & 32'h0000_0018, 32'h0000_0000, "ovf cleared");
   endtask
   // last two rows run with the cpu idle
   task automatic t_modes();
      logic [31:0] ctl [12] = '{32'h0000_8000, 32'h0000_8001,
         32'h0000_8002, 32'h0000_8003, 32'h0000_8004, 32'h0000_8005,
         32'h0000_8206, 32'h0000_8006, 32'h0000_8007, 32'h0000_0003,
         32'h0000_A003, 32'h0000_8003};
      int ex [12] = '{0, 32, 16, 16, 4, 1, 32, 31, 0, 0, 0, 16};
      int c;
      for (int i = 0; i < 12; i++) begin
         cpu_idle <= (i >= 10);
         run(ctl[i], 32, c);
         chk(c, ex[i], "captures");
         chk(irq_n, ex[i], "irqs");
         chk(wake_n, (i == 11) ? 32 : 0, "wakes");
      end
      cpu_idle <= 1'b0;
   endtask
   task automatic t_icnt();
      int ex [4] = '{8, 4, 2, 2};
      int c;
      for (int k = 0; k < 4; k++) begin
         run(32'h0000_8003 | (k << ICC_ICNT_LSB), 16, c);
         chk(irq_n, ex[k], "irq per count");
      end
   endtask
   task automatic t_sleep();
      int c;
      cpu_sleep <= 1'b1;
      run(32'h0000_8007, 8, c);
      chk(c, 0, "pin irq only");
      chk(irq_n, 8, "pin irqs");
      chk(wake_n, 8, "sleep wakes");
      cpu_sleep <= 1'b0;
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      hold <= 1'b1;
      t_regs();
      t_tbase();
      t_fifo();
      t_modes();
      t_icnt();
      t_sleep();
      complete_run();
   end
   // runs take about 4500 cycles; a hang is cut well beyond that
   initial begin
      repeat (60000) @(posedge hclk);
      err_total++;
      complete_run();
   end
endmodule
`default_nettype wire
